// ===== bench/tb_pmc_power_mode_controller.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pmc_power_mode_controller
  import pmc_pkg::*;
;
  logic                  ref_clk_i;
  logic                  nrst_i;
  logic                  mode_req_i;
  pmc_mode_t             mode_sel_i;
  logic                  tmpl_act_we_i;
  logic [PMC_TMPL_W-1:0] tmpl_act_i;
  logic                  tmpl_alt_we_i;
  logic [PMC_TMPL_W-1:0] tmpl_alt_i;
  logic                  core_reg_we_i;
  logic [1:0]            core_reg_en_i;
  pmc_wake_t             wake_src_i;
  pmc_wake_t             wake_en_i;
  logic                  irq_any_i;
  logic                  mode_o;
  pmc_mode_t             cur_mode_o;
  logic [PMC_TMPL_W-1:0] subsys_en_o;
  pmc_supply_t           supply_o;
  logic                  clocks_run_o;
  logic                  wake_evt_o;
  int                    n_mismatch;
  int                    comparisons;

  pmc_power_mode_controller u_pmc_power_mode_controller (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .mode_req_i(mode_req_i), .mode_sel_i(mode_sel_i),
    .tmpl_act_we_i(tmpl_act_we_i), .tmpl_act_i(tmpl_act_i), .tmpl_alt_we_i(tmpl_alt_we_i),
    .tmpl_alt_i(tmpl_alt_i), .core_reg_we_i(core_reg_we_i), .core_reg_en_i(core_reg_en_i),
    .wake_src_i(wake_src_i), .wake_en_i(wake_en_i), .irq_any_i(irq_any_i), .mode_o(mode_o),
    .cur_mode_o(cur_mode_o), .subsys_en_o(subsys_en_o), .supply_o(supply_o),
    .clocks_run_o(clocks_run_o), .wake_evt_o(wake_evt_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic req(input pmc_mode_t m);
    mode_sel_i = m;
    mode_req_i = 1'b1;
    tick(1);
    mode_req_i = 1'b0;
    // one idle edge keeps back to back requests from rewriting the strobe at once
    tick(1);
  endtask

  // the pulse lasts one cycle, so it is polled once per cycle after each edge
  task automatic wait_wake(input int lim);
    int n;
    n = 0;
    while (wake_evt_o !== 1'b1 && n < lim + 2) begin
      tick(1);
      n++;
    end
    chk(8'(n <= lim), 8'h01);
    chk(8'(cur_mode_o), 8'(PMC_ACTIVE));
    chk(8'(subsys_en_o[PMC_CPU_BIT]), 8'h01);
  endtask

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_mismatch++;
    complete_run();
  end

  initial begin
    n_mismatch = 0; comparisons = 0; nrst_i = 1'b0; mode_req_i = 1'b0; mode_sel_i = PMC_ACTIVE;
    tmpl_act_we_i = 1'b0; tmpl_act_i = 8'h00; tmpl_alt_we_i = 1'b0; tmpl_alt_i = 8'h00;
    core_reg_we_i = 1'b0; core_reg_en_i = 2'b11; irq_any_i = 1'b0;
    wake_src_i = pmc_wake_t'(6'h00); wake_en_i = pmc_wake_t'(6'h00);
    tick(5);
    nrst_i = 1'b1;
    tick(1);
    chk(8'(cur_mode_o), 8'(PMC_ACTIVE));
    chk(subsys_en_o, PMC_TMPL_RST);
    chk(8'(supply_o), 8'h2f);
    chk(8'({mode_o, clocks_run_o, wake_evt_o}), 8'h06);
    tmpl_act_i = 8'h5a; tmpl_act_we_i = 1'b1; tick(1); tmpl_act_we_i = 1'b0;
    chk(subsys_en_o, 8'h5a);
    tmpl_alt_i = 8'h3c; tmpl_alt_we_i = 1'b1; tick(1); tmpl_alt_we_i = 1'b0;
    chk(subsys_en_o, 8'h5a);
    req(PMC_ALT);
    chk(8'({mode_o, cur_mode_o}), 8'h05);
    chk(subsys_en_o, 8'h3c);
    irq_any_i = 1'b1;
    wait_wake(4);
    irq_any_i = 1'b0;
    chk(subsys_en_o, 8'h5b);
    req(PMC_SLEEP);
    chk(8'({mode_o, cur_mode_o}), 8'(PMC_SLEEP));
    chk(subsys_en_o, PMC_SLEEP_KEEP);
    chk(8'({supply_o.sleep_buzz, supply_o.internal_low_speed_osc, supply_o.watch_crystal_osc}), 8'h07);
    req(PMC_ACTIVE);
    wake_src_i = pmc_wake_t'(6'h08);
    tick(30);
    chk(8'(cur_mode_o), 8'(PMC_SLEEP));
    wake_en_i = pmc_wake_t'(6'h3f);
    wait_wake(PMC_SLP_WAKE_CYC);
    wake_src_i = pmc_wake_t'(6'h00);
    tick(1);
    for (int i = 0; i < 6; i++) begin
      req(PMC_SLEEP);
      tick(3);
      wake_src_i = pmc_wake_t'(6'h01 << i);
      wait_wake(PMC_SLP_WAKE_CYC);
      wake_src_i = pmc_wake_t'(6'h00);
      tick(1);
    end
    req(PMC_HIBERNATE);
    chk(8'({mode_o, cur_mode_o}), 8'(PMC_HIBERNATE));
    chk(8'(supply_o), 8'h20);
    chk(8'(clocks_run_o), 8'h00);
    chk(subsys_en_o, 8'h00);
    wake_src_i = pmc_wake_t'(6'h3d);
    irq_any_i = 1'b1;
    tick(50);
    chk(8'({clocks_run_o, cur_mode_o}), 8'(PMC_HIBERNATE));
    irq_any_i = 1'b0;
    wake_src_i = pmc_wake_t'(6'h02);
    wait_wake(PMC_HIB_WAKE_CYC);
    wake_src_i = pmc_wake_t'(6'h00);
    chk(8'(clocks_run_o), 8'h01);
    core_reg_en_i = 2'b00; core_reg_we_i = 1'b1; tick(1); core_reg_we_i = 1'b0;
    // the regulator enables reach the supply outputs one edge after the write
    tick(1);
    chk(8'({supply_o.core_analog_supply, supply_o.core_digital_supply}), 8'h00);
    req(PMC_SLEEP);
    irq_any_i = 1'b1;
    wait_wake(PMC_SLP_WAKE_CYC);
    irq_any_i = 1'b0;
    req(PMC_ALT);
    req(PMC_ACTIVE);
    chk(8'({mode_o, cur_mode_o}), 8'h04);
    chk(subsys_en_o, 8'h5b);
    req(PMC_ALT);
    nrst_i = 1'b0;
    tick(2);
    nrst_i = 1'b1;
    tick(1);
    chk(8'(cur_mode_o), 8'(PMC_ACTIVE));
    chk(subsys_en_o, PMC_TMPL_RST);
    chk(8'(supply_o), 8'h2f);
    complete_run();
  end
endmodule
`default_nettype wire

// ===== pkg/pmc_pkg.sv
`default_nettype none
package pmc_pkg;
  typedef enum logic [1:0] {
    PMC_ACTIVE    = 2'b00,
    PMC_ALT       = 2'b01,
    PMC_SLEEP     = 2'b10,
    PMC_HIBERNATE = 2'b11
  } pmc_mode_t;

  typedef enum logic [2:0] {
    PMC_ST_RUN      = 3'b000,
    PMC_ST_SLEEP    = 3'b001,
    PMC_ST_HIB      = 3'b010,
    PMC_ST_WAKE_SLP = 3'b011,
    PMC_ST_WAKE_HIB = 3'b100
  } pmc_state_t;

  // wakeup sources, one bit each
  typedef struct packed {
    logic low_voltage_detector;
    logic central_timewheel_counter;
    logic rtc;
    logic i2c;
    logic pin_interrupt_unit;
    logic comparator;
  } pmc_wake_t;

  // regulator and low-speed clock enables
  typedef struct packed {
    logic hibernate_reg;
    logic sleep_buzz;
    logic core_analog_supply;
    logic core_digital_supply;
    logic internal_low_speed_osc;
    logic watch_crystal_osc;
  } pmc_supply_t;

  localparam int          PMC_TMPL_W    = 8;
  localparam int          PMC_CPU_BIT   = 0;
  localparam logic [7:0]  PMC_TMPL_RST  = 8'hff;
  localparam logic [7:0]  PMC_SLEEP_KEEP = 8'h00;
  localparam int          PMC_CLK_MHZ   = 100;
  localparam int          PMC_SLP_WAKE_NS = 15000;
  localparam int          PMC_HIB_WAKE_NS = 100000;
  // longest times round down
  localparam int          PMC_SLP_WAKE_CYC = (PMC_SLP_WAKE_NS * PMC_CLK_MHZ) / 1000 - 1;
  localparam int          PMC_HIB_WAKE_CYC = (PMC_HIB_WAKE_NS * PMC_CLK_MHZ) / 1000 - 1;
  localparam int          PMC_CNT_W     = 14;
  localparam logic [13:0] PMC_SLP_SETTLE = 14'h0010;
  localparam logic [13:0] PMC_HIB_SETTLE = 14'h0040;
endpackage
`default_nettype wire

// ===== rtl/pmc_power_mode_controller.sv
// Summary of operation
// - four modes ranked active, alternate active, sleep, hibernate.
// - in active modes each subsystem follows its template bit.
// - active entered on wakeup, reset or request; enabled interrupts wake.
// - alternate active entered only by explicit register request.
// - sleep disables all subsystems regardless of template.
// - sleep keeps slow clocks; listed sources wake within 15 us.
// - sleep runs digital and analog regulators buzzed.
// - hibernate stops clocks; only pin interrupt wakes within 100 us.
// - core regulators enabled after reset; software may disable them.
// - wakeup returns to active and forces processor enabled.
// - processor may clear its enable; next wakeup re-enables it.
`timescale 1ns/1ps
`default_nettype none
module pmc_power_mode_controller
  import pmc_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  nrst_i,
  input  wire logic                  mode_req_i,
  input  wire pmc_mode_t             mode_sel_i,
  input  wire logic                  tmpl_act_we_i,
  input  wire logic [PMC_TMPL_W-1:0] tmpl_act_i,
  input  wire logic                  tmpl_alt_we_i,
  input  wire logic [PMC_TMPL_W-1:0] tmpl_alt_i,
  input  wire logic                  core_reg_we_i,
  input  wire logic [1:0]            core_reg_en_i,
  input  wire pmc_wake_t             wake_src_i,
  input  wire pmc_wake_t             wake_en_i,
  input  wire logic                  irq_any_i,
  output logic                       mode_o,
  output pmc_mode_t                  cur_mode_o,
  output logic [PMC_TMPL_W-1:0]      subsys_en_o,
  output pmc_supply_t                supply_o,
  output logic                       clocks_run_o,
  output logic                       wake_evt_o
);
  ////////////////////////////////////////////////////////////////////////
  pmc_state_t             state_reg, state_next;
  pmc_mode_t              mode_reg, mode_next;
  logic [PMC_TMPL_W-1:0]  act_reg, alt_reg, act_next;
  logic [1:0]             core_reg_reg;
  logic [PMC_CNT_W-1:0]   cnt_reg, cnt_next;
  logic [PMC_TMPL_W-1:0]  en_next;
  pmc_supply_t            sup_next;
  wire pmc_wake_t slp_hits   = wake_src_i & wake_en_i;
  wire logic      slp_wake   = (|slp_hits) | irq_any_i;
  wire logic      hib_wake   = wake_src_i.pin_interrupt_unit & wake_en_i.pin_interrupt_unit;
  wire logic      in_run     = (state_reg == PMC_ST_RUN);
  wire logic      req_active = mode_req_i && in_run;
  wire logic      run_wake   = in_run && mode_reg == PMC_ALT && irq_any_i;
  wire logic      wake_done  = (cnt_reg == '0);
  wire logic      finish_wake = (state_reg == PMC_ST_WAKE_SLP || state_reg == PMC_ST_WAKE_HIB) && wake_done;
  wire logic      wake_event = finish_wake || run_wake;

  ////////////////////////////////////////////////////////////////////////
  // mode sequencing; requests sampled on the write strobe and acted next edge
  always_comb begin
    state_next = state_reg;
    mode_next  = mode_reg;
    cnt_next   = (cnt_reg != '0) ? cnt_reg - 14'h0001 : cnt_reg;
    unique case (state_reg)
      PMC_ST_RUN: begin
        if (run_wake) begin
          mode_next = PMC_ACTIVE;
        end else if (req_active) begin
          mode_next = mode_sel_i;
          if (mode_sel_i == PMC_SLEEP) state_next = PMC_ST_SLEEP;
          if (mode_sel_i == PMC_HIBERNATE) state_next = PMC_ST_HIB;
        end
      end
      PMC_ST_SLEEP: begin
        if (slp_wake) begin
          state_next = PMC_ST_WAKE_SLP;
          cnt_next   = PMC_SLP_SETTLE;
        end
      end
      PMC_ST_HIB: begin
        if (hib_wake) begin
          state_next = PMC_ST_WAKE_HIB;
          cnt_next   = PMC_HIB_SETTLE;
        end
      end
      PMC_ST_WAKE_SLP, PMC_ST_WAKE_HIB: begin
        if (wake_done) begin
          state_next = PMC_ST_RUN;
          mode_next  = PMC_ACTIVE;
        end
      end
      default: state_next = PMC_ST_RUN;
    endcase
  end

  // wake re-enables the processor; the wake wins over a same-cycle clear
  always_comb begin
    act_next = tmpl_act_we_i ? tmpl_act_i : act_reg;
    if (wake_event) act_next[PMC_CPU_BIT] = 1'b1;
  end

  always_comb begin
    en_next  = '0;
    sup_next = '0;
    sup_next.hibernate_reg = 1'b1;
    unique case (state_next)
      PMC_ST_RUN: begin
        en_next = (mode_next == PMC_ALT) ? alt_reg : act_next;
        sup_next.core_digital_supply    = core_reg_reg[0];
        sup_next.core_analog_supply     = core_reg_reg[1];
        sup_next.internal_low_speed_osc = 1'b1;
        sup_next.watch_crystal_osc      = 1'b1;
      end
      PMC_ST_SLEEP, PMC_ST_WAKE_SLP: begin
        en_next = PMC_SLEEP_KEEP;
        sup_next.sleep_buzz             = 1'b1;
        sup_next.core_digital_supply    = core_reg_reg[0];
        sup_next.core_analog_supply     = core_reg_reg[1];
        sup_next.internal_low_speed_osc = 1'b1;
        sup_next.watch_crystal_osc      = 1'b1;
      end
      default: begin
        en_next = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg    <= PMC_ST_RUN;
      mode_reg     <= PMC_ACTIVE;
      cnt_reg      <= '0;
      act_reg      <= PMC_TMPL_RST;
      alt_reg      <= PMC_TMPL_RST;
      core_reg_reg <= 2'h3;
      subsys_en_o  <= PMC_TMPL_RST;
      supply_o     <= 6'h2f;
      cur_mode_o   <= PMC_ACTIVE;
      mode_o       <= 1'b1;
      clocks_run_o <= 1'b1;
      wake_evt_o   <= 1'b0;
    end else begin
      state_reg    <= state_next;
      mode_reg     <= mode_next;
      cnt_reg      <= cnt_next;
      act_reg      <= act_next;
      alt_reg      <= tmpl_alt_we_i ? tmpl_alt_i : alt_reg;
      core_reg_reg <= core_reg_we_i ? core_reg_en_i : core_reg_reg;
      subsys_en_o  <= en_next;
      supply_o     <= sup_next;
      cur_mode_o   <= mode_next;
      mode_o       <= (mode_next == PMC_ACTIVE) || (mode_next == PMC_ALT);
      clocks_run_o <= (state_next != PMC_ST_HIB) && (state_next != PMC_ST_WAKE_HIB);
      wake_evt_o   <= wake_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checker helper: cycles spent settling after a wake; the wake limits are far
  // longer than a delay range may span, so the cycles are counted instead
  logic [PMC_CNT_W-1:0] wake_age_reg;
  wire logic            waking   = (state_reg == PMC_ST_WAKE_SLP) || (state_reg == PMC_ST_WAKE_HIB);
  wire logic            age_full = (wake_age_reg == '1);

  // saturates so that a stuck wake cannot wrap round and look fresh again
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_age_reg <= '0;
    end else if (!waking) begin
      wake_age_reg <= '0;
    end else if (!age_full) begin
      wake_age_reg <= wake_age_reg + 14'h0001;
    end
  end

  chk_sleep_wake_time: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state_reg == PMC_ST_WAKE_SLP) |-> (wake_age_reg < PMC_SLP_WAKE_CYC))
    else $error("sleep wakeup too slow");
  chk_hib_wake_time: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state_reg == PMC_ST_WAKE_HIB) |-> (wake_age_reg < PMC_HIB_WAKE_CYC))
    else $error("hibernate wakeup too slow");
  chk_hib_pin_only: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state_reg == PMC_ST_HIB && !hib_wake) |=> (state_reg == PMC_ST_HIB))
    else $error("hibernate left without pin wake");
  chk_sleep_gate_all: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state_reg == PMC_ST_SLEEP) |-> (subsys_en_o == PMC_SLEEP_KEEP && supply_o.sleep_buzz))
    else $error("sleep did not gate subsystems");
  chk_hib_supplies: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state_reg == PMC_ST_HIB) |-> (supply_o == 6'h20 && subsys_en_o == '0 && !clocks_run_o))
    else $error("hibernate supplies wrong");
  chk_wake_cpu_on: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    wake_event |=> (subsys_en_o[PMC_CPU_BIT] && cur_mode_o == PMC_ACTIVE && wake_evt_o))
    else $error("wake did not enable processor");
  chk_alt_by_req: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (cur_mode_o != PMC_ALT) ##1 (cur_mode_o == PMC_ALT) |-> $past(req_active))
    else $error("alternate active without request");
  chk_active_tmpl: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (in_run && mode_reg == PMC_ACTIVE && !$past(wake_event)) |-> (subsys_en_o == act_reg))
    else $error("active template not applied");
  chk_mode_flag: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    mode_o == (cur_mode_o == PMC_ACTIVE || cur_mode_o == PMC_ALT))
    else $error("run flag disagrees with mode");
  chk_alt_tmpl: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (in_run && mode_reg == PMC_ALT) |-> (subsys_en_o == $past(alt_reg)))
    else $error("alternate template not applied");
  chk_sleep_entry: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (req_active && mode_sel_i == PMC_SLEEP && !run_wake) |=> (state_reg == PMC_ST_SLEEP && cur_mode_o == PMC_SLEEP))
    else $error("sleep request not taken");
  chk_sleep_clocks: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state_reg == PMC_ST_SLEEP) |-> (supply_o.internal_low_speed_osc && supply_o.watch_crystal_osc && clocks_run_o))
    else $error("slow clocks stopped in sleep");
  chk_sleep_hold: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state_reg == PMC_ST_SLEEP && !slp_wake) |=> (state_reg == PMC_ST_SLEEP))
    else $error("sleep left without wake source");
  chk_hib_wake_dark: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    (state_reg == PMC_ST_WAKE_HIB) |-> (!clocks_run_o && subsys_en_o == '0))
    else $error("clocks ran during hibernate wake");
  chk_core_regs: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    in_run |-> ({supply_o.core_analog_supply, supply_o.core_digital_supply} == $past(core_reg_reg)))
    else $error("core regulator enables wrong");
  chk_wake_pulse: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
    wake_evt_o |=> !wake_evt_o)
    else $error("wake pulse longer than one cycle");
endmodule
`default_nettype wire
